/* include/fls_pkg.sv */
`default_nettype none
package fls_pkg;
	// ****************************************************************
	// register map, byte addresses on the bus
	// ****************************************************************
	localparam int          AXI_ADDR_W       = 8;
	localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
	localparam int          CTRL_FIELD_W     = 6;
	localparam logic [5:0]  CTRL_RESET       = 6'h00;
	localparam int          CTRL_BUSY_BIT    = 6;
	localparam int          STAT_EEPROM_BIT  = 0;
	localparam int          STAT_FLASH_BIT   = 1;
	localparam int          STAT_CFG_BIT     = 2;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// ****************************************************************
	// pointer addresses of the configuration and signature bytes
	// ****************************************************************
	localparam logic [15:0] ADDR_FUSE_LOW    = 16'h0000;
	localparam logic [15:0] ADDR_LOCK        = 16'h0001;
	localparam logic [15:0] ADDR_FUSE_EXT    = 16'h0002;
	localparam logic [15:0] ADDR_FUSE_HIGH   = 16'h0003;
	localparam logic [15:0] ADDR_SIG_0       = 16'h0000;
	localparam logic [15:0] ADDR_OSC_CAL     = 16'h0001;
	localparam logic [15:0] ADDR_SIG_1       = 16'h0002;
	localparam logic [15:0] ADDR_SIG_2       = 16'h0004;
	localparam logic [1:0]  LOCK_UNASSIGNED  = 2'h3;
	localparam logic [7:0]  RESERVED_BYTE    = 8'hFF;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int          WIN_W            = 3;
	localparam logic [2:0]  LOAD_WINDOW      = 3'h3;
	localparam logic [2:0]  STORE_WINDOW     = 3'h4;
	localparam int          CLK_PERIOD_NS    = 50;
	localparam int          FLASH_MIN_NS     = 3700000;
	localparam int          FLASH_MAX_NS     = 4500000;
	localparam int          FLASH_MIN_CYCLES = (FLASH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          FLASH_MAX_CYCLES = FLASH_MAX_NS / CLK_PERIOD_NS;
	localparam int          FLASH_CNT_W      = 17;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef struct packed {
		logic signature_read_select;
		logic concurrent_section_reenable;
		logic lock_read_select;
		logic page_write_select;
		logic page_erase_select;
		logic store_program_enable;
	} fls_ctrl_t;

	typedef enum logic [1:0] {
		FLS_OP_NONE,
		FLS_OP_ERASE,
		FLS_OP_WRITE,
		FLS_OP_LOCK
	} fls_op_t;
endpackage
`default_nettype wire

/* hw/fls_cycle_timer.sv */
`default_nettype none
module fls_cycle_timer #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic [W-1:0] start_value,
	input  wire logic         abort,
	output logic      [W-1:0] count,
	output logic              running,
	output logic              expire
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (start) begin
			count_next = start_value;
		end else if (abort) begin
			count_next = '0;
		end else if (count_reg != '0) begin
			count_next = count_reg - W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count   = count_reg;
	assign running = (count_reg != '0);
	// last counted cycle: the edge ending it empties the counter
	assign expire  = (count_reg == W'(1)) && !start && !abort;
endmodule
`default_nettype wire

/* hw/fls_readback.sv */
// Behaviour
// - lock byte read at pointer 0x0001 armed
// - armed bits clear on read or timeout
// - unarmed load reads ordinary program memory
// - lock byte layout bits 5..0, 7..6 unassigned
// - pointer 0x0000 returns low fuse byte
// - pointer 0x0003 returns high fuse byte
// - pointer 0x0002 returns extended fuse byte
// - programmed reads zero, unprogrammed reads one
// - signature byte read at pointer when armed
// - signature arm self-clears on read or timeout
// - identification bytes at 0x0000, 0x0002, 0x0004
// - calibration byte at 0x0001, others reserved
// - flash write survives reset while supply holds
// - flash writes last 3.7 to 4.5 ms
// - busy section needs reenable before reading
// - eeprom write blocks config reads, programming
`default_nettype none
module fls_readback #(
	parameter int unsigned FLASH_OP_CYCLES = fls_pkg::FLASH_MIN_CYCLES
) (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic                           por_n,
	input  wire logic [fls_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                     s_axi_awprot,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [fls_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                     s_axi_arprot,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	input  wire logic                           instr_load,
	input  wire logic                           instr_store,
	input  wire logic [15:0]                    instr_addr,
	input  wire logic [7:0]                     instr_data,
	output logic [15:0]                         pm_rd_addr,
	input  wire logic [7:0]                     pm_rd_data,
	output logic                                load_valid,
	output logic [7:0]                          load_data,
	input  wire logic [7:0]                     fuse_low_programmed,
	input  wire logic [7:0]                     fuse_high_programmed,
	input  wire logic [7:0]                     ext_fuse_programmed,
	input  wire logic [5:0]                     lock_programmed,
	input  wire logic [7:0]                     sig_byte0,
	input  wire logic [7:0]                     sig_byte1,
	input  wire logic [7:0]                     sig_byte2,
	input  wire logic [7:0]                     osc_cal,
	input  wire logic                           eeprom_write_enable_flag,
	output logic                                flash_op_active,
	output fls_pkg::fls_op_t                    flash_op_kind,
	output logic                                lock_wr_strobe,
	output logic [7:0]                          lock_wr_data,
	output logic                                concurrent_section_busy_flag
);
	// ****************************************************************
	// bus slave state
	// ****************************************************************
	logic                           aw_hold_reg,  aw_hold_next;
	logic [fls_pkg::AXI_ADDR_W-1:0] awaddr_reg,   awaddr_next;
	logic                           w_hold_reg,   w_hold_next;
	logic [31:0]                    wdata_reg,    wdata_next;
	logic [3:0]                     wstrb_reg,    wstrb_next;
	logic                           bvalid_reg,   bvalid_next;
	logic [1:0]                     bresp_reg,    bresp_next;
	logic                           rvalid_reg,   rvalid_next;
	logic [31:0]                    rdata_reg,    rdata_next;
	logic [1:0]                     rresp_reg,    rresp_next;
	logic                           wr_fire;

	// ****************************************************************
	// control state
	// ****************************************************************
	fls_pkg::fls_ctrl_t             ctrl_reg,     ctrl_next;
	logic                           busy_reg,     busy_next;
	logic                           cfg_reg,      cfg_next;
	logic                           load_v_reg,   load_v_next;
	logic [7:0]                     load_d_reg,   load_d_next;
	fls_pkg::fls_op_t               kind_reg,     kind_next;
	logic [7:0]                     lock_d_reg,   lock_d_next;
	logic                           lock_s_reg,   lock_s_next;
	logic                           win_start;
	logic [fls_pkg::WIN_W-1:0]      win_value;
	logic                           win_abort;
	logic [fls_pkg::WIN_W-1:0]      win_count;
	logic                           win_running;
	logic                           flash_start;
	logic                           flash_running;
	logic                           flash_expire;
	logic                           load_ok;
	logic                           store_ok;
	logic                           cfg_read;
	logic [7:0]                     cfg_byte;
	logic [6:0]                     ctrl_view;
	logic [2:0]                     status_view;

	// ****************************************************************
	// timers
	// ****************************************************************
	fls_cycle_timer #(.W(fls_pkg::WIN_W)) u_window (
		.clk         (aclk),
		.rst_n       (aresetn),
		.start       (win_start),
		.start_value (win_value),
		.abort       (win_abort),
		.count       (win_count),
		.running     (win_running),
		.expire      ()
	);

	// reset by supply only, so an operation begun before a system reset runs to its end
	fls_cycle_timer #(.W(fls_pkg::FLASH_CNT_W)) u_flash_timer (
		.clk         (aclk),
		.rst_n       (por_n),
		.start       (flash_start),
		.start_value (fls_pkg::FLASH_CNT_W'(FLASH_OP_CYCLES)),
		.abort       (1'b0),
		.count       (),
		.running     (flash_running),
		.expire      (flash_expire)
	);

	// ****************************************************************
	// configuration byte select
	// ****************************************************************
	always_comb begin
		cfg_byte = fls_pkg::RESERVED_BYTE;
		if (ctrl_reg.lock_read_select) begin
			case (instr_addr)
				fls_pkg::ADDR_FUSE_LOW:  cfg_byte = ~fuse_low_programmed;
				fls_pkg::ADDR_LOCK:      cfg_byte = {fls_pkg::LOCK_UNASSIGNED, ~lock_programmed};
				fls_pkg::ADDR_FUSE_EXT:  cfg_byte = ~ext_fuse_programmed;
				fls_pkg::ADDR_FUSE_HIGH: cfg_byte = ~fuse_high_programmed;
				default:                 cfg_byte = fls_pkg::RESERVED_BYTE;
			endcase
		end else begin
			case (instr_addr)
				fls_pkg::ADDR_SIG_0:     cfg_byte = sig_byte0;
				fls_pkg::ADDR_OSC_CAL:   cfg_byte = osc_cal;
				fls_pkg::ADDR_SIG_1:     cfg_byte = sig_byte1;
				fls_pkg::ADDR_SIG_2:     cfg_byte = sig_byte2;
				default:                 cfg_byte = fls_pkg::RESERVED_BYTE;
			endcase
		end
	end

	// window count is 4 in the first cycle after the arming write, so 2 marks the third
	assign load_ok  = win_running && ctrl_reg.store_program_enable &&
		(ctrl_reg.signature_read_select || win_count >= (fls_pkg::STORE_WINDOW - fls_pkg::LOAD_WINDOW + 3'h1));
	assign store_ok = win_running && ctrl_reg.store_program_enable && !ctrl_reg.signature_read_select;
	assign cfg_read = load_ok && !eeprom_write_enable_flag &&
		(ctrl_reg.lock_read_select || ctrl_reg.signature_read_select);

	// ****************************************************************
	// control next state
	// ****************************************************************
	always_comb begin
		ctrl_next   = ctrl_reg;
		busy_next   = busy_reg;
		cfg_next    = cfg_reg;
		load_v_next = 1'b0;
		load_d_next = load_d_reg;
		kind_next   = kind_reg;
		lock_d_next = lock_d_reg;
		lock_s_next = flash_expire && (kind_reg == fls_pkg::FLS_OP_LOCK);
		win_start   = 1'b0;
		win_value   = fls_pkg::STORE_WINDOW;
		win_abort   = 1'b0;
		flash_start = 1'b0;
		if (flash_expire) begin
			ctrl_next = fls_pkg::fls_ctrl_t'(fls_pkg::CTRL_RESET);
			kind_next = fls_pkg::FLS_OP_NONE;
		end
		if (instr_load) begin
			load_v_next = 1'b1;
			cfg_next    = cfg_read;
			load_d_next = cfg_read ? cfg_byte : pm_rd_data;
		end
		// a running operation or an eeprom write refuses new arming
		if (wr_fire && awaddr_reg == fls_pkg::CTRL_OFFSET && wstrb_reg[0] &&
				!eeprom_write_enable_flag && !flash_running) begin
			ctrl_next = fls_pkg::fls_ctrl_t'(wdata_reg[fls_pkg::CTRL_FIELD_W-1:0]);
			if (wdata_reg[0]) begin
				win_start = 1'b1;
				win_value = wdata_reg[5] ? fls_pkg::LOAD_WINDOW : fls_pkg::STORE_WINDOW;
			end else begin
				ctrl_next = fls_pkg::fls_ctrl_t'(fls_pkg::CTRL_RESET);
			end
		end else if (instr_load && cfg_read) begin
			ctrl_next = fls_pkg::fls_ctrl_t'(fls_pkg::CTRL_RESET);
			win_abort = 1'b1;
		end else if (instr_store && store_ok && !eeprom_write_enable_flag) begin
			win_abort = 1'b1;
			ctrl_next = fls_pkg::fls_ctrl_t'(fls_pkg::CTRL_RESET);
			if (ctrl_reg.page_erase_select || ctrl_reg.page_write_select || ctrl_reg.lock_read_select) begin
				ctrl_next   = ctrl_reg;
				flash_start = 1'b1;
				if (ctrl_reg.lock_read_select) begin
					kind_next   = fls_pkg::FLS_OP_LOCK;
					lock_d_next = instr_data;
				end else begin
					kind_next = ctrl_reg.page_erase_select ? fls_pkg::FLS_OP_ERASE : fls_pkg::FLS_OP_WRITE;
					busy_next = 1'b1;
				end
			end else if (ctrl_reg.concurrent_section_reenable) begin
				busy_next = 1'b0;
			end
		end
		// last window cycle with nothing taken ends the arm; a signature load or a store there is served first
		if (win_count == 3'h1 && !win_start && !win_abort) begin
			ctrl_next = fls_pkg::fls_ctrl_t'(fls_pkg::CTRL_RESET);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg   <= fls_pkg::fls_ctrl_t'(fls_pkg::CTRL_RESET);
			busy_reg   <= 1'b0;
			cfg_reg    <= 1'b0;
			load_v_reg <= 1'b0;
			load_d_reg <= 8'h00;
		end else begin
			ctrl_reg   <= ctrl_next;
			busy_reg   <= busy_next;
			cfg_reg    <= cfg_next;
			load_v_reg <= load_v_next;
			load_d_reg <= load_d_next;
		end
	end

	// operation bookkeeping follows the supply reset like its timer
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			kind_reg   <= fls_pkg::FLS_OP_NONE;
			lock_d_reg <= 8'h00;
			lock_s_reg <= 1'b0;
		end else begin
			kind_reg   <= kind_next;
			lock_d_reg <= lock_d_next;
			lock_s_reg <= lock_s_next;
		end
	end

	// ****************************************************************
	// bus slave
	// ****************************************************************
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign wr_fire       = aw_hold_reg && w_hold_reg && !bvalid_reg;

	// enable reads set while an operation runs even after a system reset
	assign ctrl_view   = {busy_reg, ctrl_reg[5:1], ctrl_reg.store_program_enable | flash_running};
	assign status_view = {cfg_reg, flash_running, eeprom_write_enable_flag};

	always_comb begin
		aw_hold_next = aw_hold_reg;
		awaddr_next  = awaddr_reg;
		w_hold_next  = w_hold_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb_next  = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = (awaddr_reg == fls_pkg::CTRL_OFFSET || awaddr_reg == fls_pkg::STATUS_OFFSET) ?
				fls_pkg::RESP_OKAY : fls_pkg::RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = fls_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				fls_pkg::CTRL_OFFSET:   rdata_next = {25'h0000000, ctrl_view};
				fls_pkg::STATUS_OFFSET: rdata_next = {29'h00000000, status_view};
				default: begin
					rdata_next = 32'h00000000;
					rresp_next = fls_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg  <= '0;
			w_hold_reg  <= 1'b0;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= fls_pkg::RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h00000000;
			rresp_reg   <= fls_pkg::RESP_OKAY;
		end else begin
			aw_hold_reg <= aw_hold_next;
			awaddr_reg  <= awaddr_next;
			w_hold_reg  <= w_hold_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign s_axi_bvalid                 = bvalid_reg;
	assign s_axi_bresp                  = bresp_reg;
	assign s_axi_rvalid                 = rvalid_reg;
	assign s_axi_rdata                  = rdata_reg;
	assign s_axi_rresp                  = rresp_reg;
	// memory answers combinationally in the same cycle, so the address is passed straight on
	assign pm_rd_addr                   = instr_addr;
	assign load_valid                   = load_v_reg;
	assign load_data                    = load_d_reg;
	assign flash_op_active              = flash_running;
	assign flash_op_kind                = kind_reg;
	assign lock_wr_strobe               = lock_s_reg;
	assign lock_wr_data                 = lock_d_reg;
	assign concurrent_section_busy_flag = busy_reg;
endmodule
`default_nettype wire

/* verif/fls_core_model.sv */
`default_nettype none
module fls_core_model (
	input  wire logic        aclk,
	output logic             instr_load,
	output logic             instr_store,
	output logic [15:0]      instr_addr,
	output logic [7:0]       instr_data,
	input  wire logic [15:0] pm_rd_addr,
	output logic [7:0]       pm_rd_data
);
	// ****************************************************************
	// program memory stand-in and instruction issue
	// ****************************************************************
	// address-mixed pattern, so a plain read never looks like a config byte
	assign pm_rd_data = pm_rd_addr[7:0] ^ pm_rd_addr[15:8] ^ 8'hA5;

	initial begin
		instr_load = 1'b0;
		instr_store = 1'b0;
		instr_addr = 16'h0000;
		instr_data = 8'h00;
	end

	// one-cycle pulse; pointer moves only with the request, operand is inverted after it
	task automatic exec(input logic ld, input logic [15:0] a, input logic [7:0] d);
		instr_addr <= a;
		instr_data <= d;
		instr_load <= ld;
		instr_store <= !ld;
		@(posedge aclk);
		instr_load <= 1'b0;
		instr_store <= 1'b0;
		instr_data <= ~d;
	endtask
endmodule
`default_nettype wire

/* verif/fls_readback_checker.sv */
`default_nettype none
module fls_readback_checker #(
	parameter int unsigned FLASH_OP_CYCLES = 20
) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             por_n,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_bvalid,
	input wire logic             instr_load,
	input wire logic [7:0]       pm_rd_data,
	input wire logic             load_valid,
	input wire logic [7:0]       load_data,
	input wire logic             eeprom_write_enable_flag,
	input wire logic             flash_op_active,
	input wire fls_pkg::fls_op_t flash_op_kind,
	input wire logic             lock_wr_strobe,
	input wire logic             concurrent_section_busy_flag
);
	logic [2:0]  age_reg, age_next;
	logic        bv_reg;
	logic [31:0] run_reg, run_next;

	// ****************************************************************
	// helpers: cycles since a write answer, length of a flash run
	// ****************************************************************
	always_comb begin
		age_next = (s_axi_bvalid && !bv_reg) ? 3'h0 : age_reg + {2'h0, age_reg != 3'h7};
		run_next = flash_op_active ? run_reg + 32'h1 : 32'h0;
	end
	// the run counter ignores the system reset, as the flash timer does
	always_ff @(posedge aclk) begin
		bv_reg <= aresetn && s_axi_bvalid;
		age_reg <= aresetn ? age_next : 3'h7;
		run_reg <= por_n ? run_next : 32'h0;
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_lock_done;
		$fell(flash_op_active) && $past(flash_op_kind) == fls_pkg::FLS_OP_LOCK;
	endsequence
	sequence s_stale_load;
		instr_load && age_reg >= 3'h3 && !(s_axi_bvalid && !bv_reg);
	endsequence

	a_load_answer: assert property (instr_load |=> load_valid) else $error("load not answered");
	a_load_lone: assert property (!instr_load |=> !load_valid && $stable(load_data))
		else $error("load result moved without a load");
	a_window_gone: assert property (s_stale_load |=> load_data == $past(pm_rd_data))
		else $error("stale arm gave a config read");
	a_eeprom_block: assert property (instr_load && eeprom_write_enable_flag |=> load_data == $past(pm_rd_data))
		else $error("config read during eeprom write");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
	a_flash_length: assert property ($fell(flash_op_active) |-> run_reg == FLASH_OP_CYCLES)
		else $error("flash run length wrong");
	a_lock_strobe: assert property (s_lock_done |-> ##[0:1] lock_wr_strobe) else $error("no lock write");
	a_busy_rises: assert property ($rose(flash_op_active) && flash_op_kind inside {fls_pkg::FLS_OP_ERASE,
		fls_pkg::FLS_OP_WRITE} |-> ##[0:1] concurrent_section_busy_flag) else $error("busy flag not set");
endmodule

bind fls_readback fls_readback_checker #(.FLASH_OP_CYCLES(FLASH_OP_CYCLES)) fls_readback_checker_i (.aclk, .aresetn,
	.por_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .instr_load, .pm_rd_data, .load_valid,
	.load_data, .eeprom_write_enable_flag, .flash_op_active, .flash_op_kind, .lock_wr_strobe,
	.concurrent_section_busy_flag);
`default_nettype wire

/* verif/fls_readback_bench.sv */
`default_nettype none
module fls_readback_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned OPC = 20;
	logic             aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, eeprom_write_enable_flag = 1'b0;
	logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]      s_axi_wdata = 32'h0, s_axi_rdata, rd_word;
	logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic             s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [2:0]       s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0]       s_axi_wstrb = 4'hF;
	logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]       s_axi_bresp, s_axi_rresp, rsp;
	logic             instr_load, instr_store, load_valid, flash_op_active, lock_wr_strobe;
	logic             concurrent_section_busy_flag;
	logic [15:0]      instr_addr, pm_rd_addr, a;
	logic [7:0]       instr_data, pm_rd_data, load_data, lock_wr_data, sig_byte0, sig_byte1, sig_byte2, osc_cal;
	logic [7:0]       fuse_low_programmed, fuse_high_programmed, ext_fuse_programmed;
	logic [5:0]       lock_programmed;
	logic [63:0]      rnd;
	fls_pkg::fls_op_t flash_op_kind;
	int               miscompares = 0, compares = 0, n;
	always #25 aclk = ~aclk;
	fls_readback #(.FLASH_OP_CYCLES(OPC)) fls_readback_i (.aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr_load, .instr_store, .instr_addr, .instr_data, .pm_rd_addr,
		.pm_rd_data, .load_valid, .load_data, .fuse_low_programmed, .fuse_high_programmed, .ext_fuse_programmed,
		.lock_programmed, .sig_byte0, .sig_byte1, .sig_byte2, .osc_cal, .eeprom_write_enable_flag, .flash_op_active,
		.flash_op_kind, .lock_wr_strobe, .lock_wr_data, .concurrent_section_busy_flag);
	fls_core_model fls_core_model_i (.aclk, .instr_load, .instr_store, .instr_addr, .instr_data, .pm_rd_addr,
		.pm_rd_data);

	// ****************************************************************
	// expectations and bus tasks
	// ****************************************************************
	function automatic logic [7:0] cfg_exp(input logic sig, input logic [15:0] p);
		case ({sig, p})
			17'h00000: return ~fuse_low_programmed;
			17'h00001: return {2'h3, ~lock_programmed};
			17'h00002: return ~ext_fuse_programmed;
			17'h00003: return ~fuse_high_programmed;
			17'h10000: return sig_byte0;
			17'h10001: return osc_cal;
			17'h10002: return sig_byte1;
			17'h10004: return sig_byte2;
			default: return 8'hFF;
		endcase
	endfunction
	function automatic logic [7:0] pm_exp(input logic [15:0] p);
		return p[7:0] ^ p[15:8] ^ 8'hA5;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic fa, fw, fb;
		fb = 1'b0;
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!fb) begin
			@(negedge aclk);
			fa = s_axi_awready;
			fw = s_axi_wready;
			fb = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (fa) s_axi_awvalid <= 1'b0;
			if (fw) s_axi_wvalid <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input logic [1:0] er);
		logic fa, fr;
		fr = 1'b0;
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		while (!fr) begin
			@(negedge aclk);
			fa = s_axi_arready;
			fr = s_axi_rvalid;
			rd_word = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (fa) s_axi_arvalid <= 1'b0;
		end
		if (exp !== 32'hFFFFFFFF) chk(rd_word, exp);
		chk(rsp, er);
	endtask
	task automatic cfg(input logic [7:0] ctl, input logic [15:0] p, input int gap, input logic [7:0] exp);
		wr(8'h00, {24'h0, ctl});
		repeat (gap) @(posedge aclk);
		fls_core_model_i.exec(1'b1, p, 8'h00);
		@(negedge aclk);
		chk(load_valid, 1'b1);
		chk(load_data, exp);
		@(posedge aclk);
	endtask
	task automatic idle;
		do rd(8'h00, 32'hFFFFFFFF, 2'h0); while (rd_word[0] !== 1'b0);
	endtask
	task automatic print_verdict;
		if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		void'($urandom(79));
		rnd = {$urandom, $urandom};
		{fuse_low_programmed, fuse_high_programmed, ext_fuse_programmed, sig_byte0} = rnd[31:0];
		{sig_byte1, sig_byte2, osc_cal, lock_programmed} = rnd[61:32];
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		por_n <= 1'b1;
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		rd(8'h08, 32'h0, 2'h2);
		wr(8'h08, 32'h1);
		chk(rsp, 2'h2);
		for (a = 16'h0; a < 16'h5; a++) cfg(8'h09, a, $urandom_range(1, 0), cfg_exp(1'b0, a));
		rd(8'h00, 32'h0, 2'h0);
		for (a = 16'h0; a < 16'h6; a++) cfg(8'h21, a, $urandom_range(1, 0), cfg_exp(1'b1, a));
		cfg(8'h21, 16'h0, 2, pm_exp(16'h0));
		cfg(8'h09, 16'h1, 3, pm_exp(16'h1));
		rd(8'h00, 32'h0, 2'h0);
		cfg(8'h00, 16'h3, 4, pm_exp(16'h3));
		eeprom_write_enable_flag <= 1'b1;
		rd(8'h04, 32'h1, 2'h0);
		cfg(8'h09, 16'h0, 0, pm_exp(16'h0));
		eeprom_write_enable_flag <= 1'b0;
		wr(8'h00, 32'h03);
		fls_core_model_i.exec(1'b0, 16'h0040, 8'h00);
		n = 0;
		@(negedge aclk);
		while (flash_op_active === 1'b1) begin
			@(negedge aclk);
			n++;
		end
		chk(n, OPC);
		@(posedge aclk);
		rd(8'h00, 32'h40, 2'h0);
		wr(8'h00, 32'h11);
		fls_core_model_i.exec(1'b0, 16'h0000, 8'h00);
		rd(8'h00, 32'h0, 2'h0);
		wr(8'h00, 32'h05);
		fls_core_model_i.exec(1'b0, 16'h0080, 8'h00);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(flash_op_active, 1'b1);
		@(posedge aclk);
		idle();
		wr(8'h00, 32'h09);
		fls_core_model_i.exec(1'b0, 16'h0001, rnd[63:56]);
		n = 0;
		while (lock_wr_strobe !== 1'b1 && n < 100) begin
			@(negedge aclk);
			n++;
		end
		chk(lock_wr_strobe, 1'b1);
		chk(lock_wr_data, rnd[63:56]);
		print_verdict();
	end

	initial begin
		repeat (3000) @(posedge aclk);
		miscompares++;
		print_verdict();
	end
endmodule
`default_nettype wire
